// [rtl/adc_seq_defs.svh]
// Offsets, field positions, reset values and timing counts of the converter
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define ADC_OFF_CTRL_MAIN   3'h0
`define ADC_OFF_REF_PORT    3'h1
`define ADC_OFF_TIMING      3'h2
`define ADC_OFF_RES_HIGH    3'h3
`define ADC_OFF_RES_LOW     3'h4
`define ADC_OFF_IRQ_STATUS  3'h5
`define ADC_OFF_IRQ_MASK    3'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADC_CONV_ON_BIT     0
`define ADC_GO_BIT          1
`define ADC_CHAN_LSB        2
`define ADC_PCFG_LSB        0
`define ADC_VREF_LSB        4
`define ADC_CLKSEL_LSB      0
`define ADC_ACQ_LSB         3
`define ADC_JUSTIFY_BIT     7
`define ADC_DONE_BIT        0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADC_RST_CTRL_MAIN   8'h00
`define ADC_RST_REF_PORT    8'h00
`define ADC_RST_TIMING      8'h00
`define ADC_RST_RESULT      8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define ADC_CLK_PERIOD_NS   25
`define ADC_TCY_NS          100
`define ADC_TCY_CLKS        ((`ADC_TCY_NS + `ADC_CLK_PERIOD_NS - 1) / \
	`ADC_CLK_PERIOD_NS)
`define ADC_CONV_TADS       12
`define ADC_RES_BITS        10

`endif

// [rtl/adc_seq_pkg.sv]
// Types shared by the converter sequencer and its clock divider
`default_nettype none

package adc_seq_pkg;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_RC_WAIT = 4'b0010,
		ST_ACQUIRE = 4'b0100,
		ST_CONVERT = 4'b1000
	} seq_state_t;

	// ------------------------------------------------------------------
	// Sequencer state record
	// ------------------------------------------------------------------
	typedef struct packed {
		seq_state_t  st;
		logic        conv_on;
		logic [3:0]  chan;
		logic [1:0]  vref;
		logic [3:0]  pcfg;
		logic        justify;
		logic [2:0]  acq_sel;
		logic [2:0]  clk_sel;
		logic [7:0]  res_hi;
		logic [7:0]  res_lo;
		logic        irq_status;
		logic        irq_mask;
		logic [7:0]  rdata;
		logic [4:0]  cnt;
		logic [2:0]  dly;
		logic [9:0]  sar;
	} seq_regs_t;

	// ------------------------------------------------------------------
	// Divider state record
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [5:0]  cnt;
	} div_regs_t;

endpackage

`default_nettype wire

// [rtl/adc_conv_clock_div.sv]
// Conversion clock tick generator from the divided system clock
`default_nettype none
`include "adc_seq_defs.svh"

module adc_conv_clock_div (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_run,
	input  wire logic [2:0]  i_sel,
	output logic             o_tick
);

	adc_seq_pkg::div_regs_t div_reg;
	adc_seq_pkg::div_regs_t div_next;
	logic [5:0]              last_cnt;

	// Divide ratio minus one for each clock select code
	always_comb begin
		unique case (i_sel)
			3'h0:    last_cnt = 6'h01;
			3'h1:    last_cnt = 6'h07;
			3'h2:    last_cnt = 6'h1f;
			3'h4:    last_cnt = 6'h03;
			3'h5:    last_cnt = 6'h0f;
			3'h6:    last_cnt = 6'h3f;
			default: last_cnt = 6'h3f; // RC codes, tick unused
		endcase
	end

	// Count restarts whenever the sequencer is not running
	always_comb begin
		div_next = div_reg;
		if (!i_run || div_reg.cnt == last_cnt) begin
			div_next.cnt = 6'h00;
		end else begin
			div_next.cnt = div_reg.cnt + 6'h01;
		end
	end

	// One pulse at the end of each conversion clock period
	assign o_tick = i_run && (div_reg.cnt == last_cnt);

	// State register
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

endmodule

`default_nettype wire

// [rtl/adc_seq_ctrl.sv]
// Control and sequencing of a 10-bit successive approximation converter
//
// Overview of operation
// R1 - Channel field routes input n to hold
// R2 - Go starts conversion, self-clears at completion
// R3 - Converter-on bit enables module and go
// R4 - Acquire selected channel first, then convert
// R5 - Acquisition time table 0 to 20 periods
// R6 - Clock select: system divider or RC clock
// R7 - RC clock waits one instruction cycle
// R8 - Format bit selects right or left justify
// R9 - Reference field selects rails or externals
// R10 - Port config sets analog versus digital pins
// R11 - Completion loads result, clears go, flags
// R12 - Reset clears registers and aborts conversion
// R13 - Sleep conversion only on RC clock
// R14 - Unimplemented control bits read zero
// R15 - Software allows acquisition after channel change
// R16 - Sampling switch opens during conversion
// R17 - Conversion takes twelve clock periods
// R18 - Result byte placement per format
// R19 - Go ignored when off; bit per period
`default_nettype none
`include "adc_seq_defs.svh"

module adc_seq_ctrl #(
	parameter int CONV_TADS = `ADC_CONV_TADS,
	parameter int TCY_CLKS  = `ADC_TCY_CLKS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [7:0]       o_rdata,
	input  wire logic        i_rc_tick,
	input  wire logic        i_sleep,
	input  wire logic        i_cmp_above,
	output logic [9:0]       o_dac_code,
	output logic [3:0]       o_channel,
	output logic             o_sample,
	output logic [1:0]       o_vref_config,
	output logic [15:0]      o_analog_pins,
	output logic             o_irq
);

	// ------------------------------------------------------------------
	// Local decode helpers
	// ------------------------------------------------------------------

	// Acquisition time in conversion clock periods
	function automatic logic [4:0] acq_periods(input logic [2:0] sel);
		unique case (sel)
			3'h0: acq_periods = 5'd0;
			3'h1: acq_periods = 5'd2;
			3'h2: acq_periods = 5'd4;
			3'h3: acq_periods = 5'd6;
			3'h4: acq_periods = 5'd8;
			3'h5: acq_periods = 5'd12;
			3'h6: acq_periods = 5'd16;
			3'h7: acq_periods = 5'd20;
		endcase
	endfunction

	// Codes 011 and 111 pick the private RC clock
	function automatic logic is_rc_clock(input logic [2:0] sel);
		is_rc_clock = (sel[1:0] == 2'b11);
	endfunction

	// High and low result bytes for the selected justification
	function automatic logic [15:0] place_result(input logic right,
		input logic [9:0] r);
		if (right) begin
			place_result = {6'h00, r[9:8], r[7:0]};
		end else begin
			place_result = {r[9:2], r[1:0], 6'h00};
		end
	endfunction

	localparam logic [4:0] LAST_TAD = 5'(CONV_TADS - 1);
	localparam logic [2:0] LAST_DLY = 3'(TCY_CLKS - 1);
	localparam int         RB       = `ADC_RES_BITS;

	// Reset images of the three control registers
	localparam logic [7:0] RST_MAIN   = `ADC_RST_CTRL_MAIN;
	localparam logic [7:0] RST_REF    = `ADC_RST_REF_PORT;
	localparam logic [7:0] RST_TIMING = `ADC_RST_TIMING;

	// ------------------------------------------------------------------
	// State and internal signals
	// ------------------------------------------------------------------
	adc_seq_pkg::seq_regs_t seq_reg;
	adc_seq_pkg::seq_regs_t seq_next;
	logic                   div_run;
	logic                   div_tick;
	logic                   tad_tick;
	logic                   rc_sel;
	logic                   busy;
	logic                   wr_ctrl;
	logic                   wr_ref;
	logic                   wr_timing;
	logic                   wr_status;
	logic                   wr_mask;
	logic                   acq_done;
	logic                   go_req;
	logic                   abort_req;
	logic                   done_evt;
	logic [4:0]             bit_idx;
	logic [9:0]             sar_cur;

	// ------------------------------------------------------------------
	// Conversion clock
	// ------------------------------------------------------------------

	// Acquisition has counted its programmed periods
	assign acq_done = (seq_reg.cnt >= acq_periods(seq_reg.acq_sel));

	// Divided system clock, held for one cycle between the two phases so
	// that every conversion period is a full one
	assign div_run = (seq_reg.st == adc_seq_pkg::ST_CONVERT) ||
		((seq_reg.st == adc_seq_pkg::ST_ACQUIRE) && !acq_done); // R17

	adc_conv_clock_div u_clock_div (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_run   (div_run),
		.i_sel   (seq_reg.clk_sel),
		.o_tick  (div_tick)
	);

	// System divider ticks are masked in sleep; RC ticks keep running
	assign rc_sel   = is_rc_clock(seq_reg.clk_sel); // R6
	assign tad_tick = rc_sel ? i_rc_tick : (div_tick && !i_sleep); // R13

	// ------------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------------
	// Busy is the go flag as software reads it
	assign busy      = (seq_reg.st != adc_seq_pkg::ST_IDLE);
	assign wr_ctrl   = i_wr && (i_addr == `ADC_OFF_CTRL_MAIN);
	assign wr_ref    = i_wr && (i_addr == `ADC_OFF_REF_PORT);
	assign wr_timing = i_wr && (i_addr == `ADC_OFF_TIMING);
	assign wr_status = i_wr && (i_addr == `ADC_OFF_IRQ_STATUS);
	assign wr_mask   = i_wr && (i_addr == `ADC_OFF_IRQ_MASK);
	assign go_req    = wr_ctrl && i_wdata[`ADC_GO_BIT] &&
		i_wdata[`ADC_CONV_ON_BIT] && !busy; // R19
	assign abort_req = wr_ctrl && busy &&
		(!i_wdata[`ADC_GO_BIT] || !i_wdata[`ADC_CONV_ON_BIT]);

	// Result bit resolved by the current conversion period
	assign bit_idx = 5'(RB - 1) - seq_reg.cnt;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		seq_next = seq_reg;
		done_evt = 1'b0;
		sar_cur  = seq_reg.sar;

		// Configuration writes
		if (wr_ctrl) begin
			seq_next.conv_on = i_wdata[`ADC_CONV_ON_BIT]; // R3
			seq_next.chan    = i_wdata[`ADC_CHAN_LSB +: 4]; // R1
		end
		// Reference and pin configuration
		if (wr_ref) begin
			seq_next.pcfg = i_wdata[`ADC_PCFG_LSB +: 4]; // R10
			seq_next.vref = i_wdata[`ADC_VREF_LSB +: 2]; // R9
		end
		// Clock, acquisition time and format
		if (wr_timing) begin
			seq_next.clk_sel = i_wdata[`ADC_CLKSEL_LSB +: 3]; // R6
			seq_next.acq_sel = i_wdata[`ADC_ACQ_LSB +: 3]; // R5
			seq_next.justify = i_wdata[`ADC_JUSTIFY_BIT]; // R8
		end
		// Interrupt mask
		if (wr_mask) begin
			seq_next.irq_mask = i_wdata[`ADC_DONE_BIT];
		end

		// Sequencer
		unique case (seq_reg.st)
			adc_seq_pkg::ST_IDLE: begin
				seq_next.cnt = 5'd0;
				seq_next.dly = 3'd0;
				if (go_req) begin
					// Channel and go may be written together
					if (is_rc_clock(seq_reg.clk_sel)) begin
						seq_next.st = adc_seq_pkg::ST_RC_WAIT; // R7
					end else begin
						seq_next.st = adc_seq_pkg::ST_ACQUIRE; // R4
					end
				end
			end
			adc_seq_pkg::ST_RC_WAIT: begin
				// One instruction cycle before the RC clock is used
				if (seq_reg.dly == LAST_DLY) begin
					seq_next.st = adc_seq_pkg::ST_ACQUIRE; // R7
				end else begin
					seq_next.dly = seq_reg.dly + 3'd1;
				end
			end
			adc_seq_pkg::ST_ACQUIRE: begin
				// Sample the selected channel for the programmed time
				if (acq_done) begin
					seq_next.st  = adc_seq_pkg::ST_CONVERT; // R4
					seq_next.cnt = 5'd0;
					seq_next.sar = 10'h200;
				end else if (tad_tick) begin
					seq_next.cnt = seq_reg.cnt + 5'd1; // R5
				end
			end
			adc_seq_pkg::ST_CONVERT: begin
				if (tad_tick) begin
					// One result bit per period, MSB first
					if (seq_reg.cnt < 5'(RB)) begin
						if (!i_cmp_above) begin
							sar_cur[bit_idx[3:0]] = 1'b0; // R19
						end
						if (bit_idx != 5'd0) begin
							sar_cur[bit_idx[3:0] - 4'd1] = 1'b1;
						end
						seq_next.sar = sar_cur;
					end
					// Periods eleven and twelve only settle the result
					if (seq_reg.cnt == LAST_TAD) begin
						// Load result, clear go, raise done
						seq_next.st = adc_seq_pkg::ST_IDLE; // R11
						done_evt    = 1'b1; // R11
						{seq_next.res_hi, seq_next.res_lo} =
							place_result(seq_reg.justify, sar_cur); // R8 R18
					end else begin
						seq_next.cnt = seq_reg.cnt + 5'd1; // R17
					end
				end
			end
			default: begin
				seq_next.st = adc_seq_pkg::ST_IDLE;
			end
		endcase

		// Software clearing go or the module drops the conversion
		// Result registers and flag keep their old values
		if (abort_req || !seq_reg.conv_on) begin
			if (busy) begin
				seq_next.st = adc_seq_pkg::ST_IDLE; // R3
				done_evt    = 1'b0;
				seq_next.res_hi = seq_reg.res_hi;
				seq_next.res_lo = seq_reg.res_lo;
			end
		end

		// Done flag: a completion in the clearing cycle wins
		if (wr_status && i_wdata[`ADC_DONE_BIT]) begin
			seq_next.irq_status = 1'b0;
		end
		if (done_evt) begin
			seq_next.irq_status = 1'b1; // R11
		end

		// Read data, valid the cycle after the strobe
		seq_next.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`ADC_OFF_CTRL_MAIN: begin
					seq_next.rdata = {2'b00, seq_reg.chan,
						busy, seq_reg.conv_on}; // R2 R3 R14
				end
				`ADC_OFF_REF_PORT: begin
					seq_next.rdata = {2'b00, seq_reg.vref,
						seq_reg.pcfg}; // R14
				end
				`ADC_OFF_TIMING: begin
					seq_next.rdata = {seq_reg.justify, 1'b0,
						seq_reg.acq_sel, seq_reg.clk_sel}; // R14
				end
				`ADC_OFF_RES_HIGH: begin
					seq_next.rdata = seq_reg.res_hi;
				end
				`ADC_OFF_RES_LOW: begin
					seq_next.rdata = seq_reg.res_lo;
				end
				`ADC_OFF_IRQ_STATUS: begin
					seq_next.rdata = {7'h00, seq_reg.irq_status};
				end
				`ADC_OFF_IRQ_MASK: begin
					seq_next.rdata = {7'h00, seq_reg.irq_mask};
				end
				default: begin
					seq_next.rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Reset returns every register to its reset value
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			seq_reg         <= '0; // R12
			seq_reg.st      <= adc_seq_pkg::ST_IDLE; // R12
			seq_reg.conv_on <= RST_MAIN[`ADC_CONV_ON_BIT];
			seq_reg.chan    <= RST_MAIN[`ADC_CHAN_LSB +: 4];
			seq_reg.vref    <= RST_REF[`ADC_VREF_LSB +: 2];
			seq_reg.pcfg    <= RST_REF[`ADC_PCFG_LSB +: 4];
			seq_reg.clk_sel <= RST_TIMING[`ADC_CLKSEL_LSB +: 3];
			seq_reg.acq_sel <= RST_TIMING[`ADC_ACQ_LSB +: 3];
			seq_reg.justify <= RST_TIMING[`ADC_JUSTIFY_BIT];
			seq_reg.res_hi  <= `ADC_RST_RESULT;
			seq_reg.res_lo  <= `ADC_RST_RESULT;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_rdata       = seq_reg.rdata;
	assign o_dac_code    = seq_reg.sar;
	assign o_channel     = seq_reg.chan; // R1
	assign o_vref_config = seq_reg.vref; // R9

	// Level interrupt while an unmasked completion is pending
	assign o_irq         = seq_reg.irq_status && seq_reg.irq_mask; // R11

	// Hold capacitor follows the input while the module is on, except while converting
	assign o_sample = seq_reg.conv_on &&
		(seq_reg.st != adc_seq_pkg::ST_CONVERT); // R16

	// Pin n is analog when config is zero or n + k <= 14
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_pin
			assign o_analog_pins[g] = (seq_reg.pcfg == 4'h0) ||
				(5'(g) + {1'b0, seq_reg.pcfg} <= 5'd14); // R10
		end
	endgenerate

endmodule

`default_nettype wire

// [tb/adc_seq_ctrl_assertions.sv]
// Checker of the converter sequencer port behaviour
`default_nettype none

module adc_seq_ctrl_check #(
	parameter int CONV_TADS = 12,
	parameter int TCY_CLKS  = 4
) (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic [2:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	input wire logic [3:0]  o_channel,
	input wire logic        o_sample,
	input wire logic [1:0]  o_vref_config,
	input wire logic [15:0] o_analog_pins,
	input wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Port relations
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_unimpl_top: assert property ($past(i_rd) && $past(i_addr) <= 3'h1
		|-> o_rdata[7:6] == 2'b00) else $error("upper control bits set");
	a_unimpl_fmt: assert property ($past(i_rd) && $past(i_addr) == 3'h2
		|-> !o_rdata[6]) else $error("format bit 6 set");
	a_pins_shape: assert property ((o_analog_pins &
		(o_analog_pins + 16'h1)) == 16'h0 && o_analog_pins != 16'h7fff)
		else $error("analog pin map not a prefix");
	a_pins_all: assert property (i_wr && i_addr == 3'h1 &&
		i_wdata[3:0] == 4'h0 |=> o_analog_pins == 16'hffff)
		else $error("config zero not all analog");
	a_chan_follow: assert property (i_wr && i_addr == 3'h0
		|=> o_channel == $past(i_wdata[5:2])) else $error("channel wrong");
	a_vref_follow: assert property (i_wr && i_addr == 3'h1
		|=> o_vref_config == $past(i_wdata[5:4])) else $error("vref wrong");
	a_off_nosample: assert property (i_wr && i_addr == 3'h0
		&& !i_wdata[0] |=> !o_sample) else $error("sampling while off");
	a_mask_quiet: assert property (i_wr && i_addr == 3'h6
		&& !i_wdata[0] |=> !o_irq) else $error("masked irq high");
	a_hold_open: assert property ($fell(o_sample) && !$past(i_wr)
		|-> !o_sample [*8]) else $error("switch closed too early");

	// Main scenarios
	c_convert: cover property ($fell(o_sample));
	c_irq: cover property ($rose(o_irq));
	c_go: cover property (i_wr && i_addr == 3'h0 && i_wdata[1:0] == 2'b11);
endmodule

bind adc_seq_ctrl adc_seq_ctrl_check #(
	.CONV_TADS(CONV_TADS),
	.TCY_CLKS (TCY_CLKS)
) adc_seq_ctrl_check_i (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_channel, .o_sample, .o_vref_config,
	.o_analog_pins, .o_irq);

`default_nettype wire

// [tb/adc_input_model.sv]
// Model of analog inputs, hold stage, comparator and RC oscillator
`default_nettype none

module adc_input_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [9:0]  i_dac_code,
	input  wire logic [3:0]  i_channel,
	input  wire logic        i_sample,
	output logic             o_cmp_above,
	output logic             o_rc_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] hold_reg;
	logic [2:0] rc_reg;

	// Hold tracks the pin only while the switch is closed
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hold_reg <= 10'h000;
			rc_reg   <= 3'h0;
		end else begin
			if (i_sample)
				hold_reg <= {i_channel, 6'h15} ^ 10'h0a3;
			rc_reg <= (rc_reg == 3'h4) ? 3'h0 : rc_reg + 3'h1;
		end
	end

	// Comparator against the trial code, free running RC tick of five
	assign o_cmp_above = hold_reg >= i_dac_code;
	assign o_rc_tick   = rc_reg == 3'h4;
endmodule

`default_nettype wire

// [tb/adc_seq_ctrl_test.sv]
// Self-checking bench of the converter sequencer
`default_nettype none

module adc_seq_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk   = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [2:0]  i_addr  = 3'h0;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr    = 1'b0;
	logic        i_rd    = 1'b0;
	logic        i_sleep = 1'b0;
	logic        cmp, tick, smp, irq;
	logic [7:0]  o_rdata;
	logic [9:0]  dac;
	logic [3:0]  chan;
	logic [1:0]  vref;
	logic [15:0] pins;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          dvt[8] = '{2, 8, 32, 5, 4, 16, 64, 5};
	int          acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

	adc_seq_ctrl adc_seq_ctrl_i (.i_clk, .i_rst_b, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_rc_tick(tick), .i_sleep,
		.i_cmp_above(cmp), .o_dac_code(dac), .o_channel(chan),
		.o_sample(smp), .o_vref_config(vref), .o_analog_pins(pins),
		.o_irq(irq));
	adc_input_model adc_input_model_i (.i_clk, .i_rst_b, .i_dac_code(dac),
		.i_channel(chan), .i_sample(smp), .o_cmp_above(cmp),
		.o_rc_tick(tick));

	// Clock of 25 ns
	always #12.5 i_clk = ~i_clk;

	// Cycle count and hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------
	// Access and check tasks
	// ------------------------------------------------------------------
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(16'(o_rdata), 16'(e));
	endtask
	task automatic wait_irq(input int t0, output int n);
		for (int k = 0; k < 3000 && irq !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		n = cyc - t0;
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		logic [9:0] l;
		logic [7:0] c;
		int         t0, n, base;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		chk(pins, 16'hffff);
		wr(3'h0, 8'hfc);
		rd(3'h0, 8'h3c);
		wr(3'h2, 8'hff);
		rd(3'h2, 8'hbf);
		for (int k = 0; k < 16; k++) begin
			c = {2'b11, 2'(k), 4'(k)};
			wr(3'h1, c);
			rd(3'h1, c & 8'h3f);
			chk(16'(vref), 16'(k % 4));
			chk(pins, k == 0 ? 16'hffff : 16'((1 << (15 - k)) - 1));
		end
		wr(3'h0, 8'h02);
		rd(3'h0, 8'h00);
		wr(3'h6, 8'h01);
		wr(3'h1, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			c = {2'b00, 4'(2 * i + 1), 2'b01};
			wr(3'h2, {i[0], 1'b0, 3'(i), 3'(i)});
			wr(3'h0, c);
			repeat (20) @(posedge i_clk);
			wr(3'h0, c | 8'h02);
			t0 = cyc;
			rd(3'h0, c | 8'h02);
			if (i == 3 || i == 4) begin
				@(posedge i_clk);
				i_sleep <= 1'b1;
				repeat (50) @(posedge i_clk);
				i_sleep <= 1'b0;
			end
			wait_irq(t0, n);
			base = (acq[i] + 12) * dvt[i] + ((i == 4) ? 50 : 0);
			chk(16'(n >= base && n <= base + dvt[i] + 8), 16'h1);
			l = {4'(2 * i + 1), 6'h15} ^ 10'h0a3;
			rd(3'h3, i[0] ? {6'h00, l[9:8]} : l[9:2]);
			rd(3'h4, i[0] ? l[7:0] : {l[1:0], 6'h00});
			rd(3'h0, c);
			chk(16'(chan), 16'(2 * i + 1));
			rd(3'h5, 8'h01);
			wr(3'h5, 8'h01);
			rd(3'h5, 8'h00);
			chk(16'(irq), 16'h0);
			$display("test conversion %0d done", i);
		end
		wr(3'h2, 8'h06);
		wr(3'h0, 8'h3f);
		repeat (100) @(posedge i_clk);
		wr(3'h0, 8'h3c);
		rd(3'h0, 8'h3c);
		repeat (800) @(posedge i_clk);
		rd(3'h5, 8'h00);
		wr(3'h0, 8'h3f);
		repeat (100) @(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int a = 0; a < 7; a++)
			rd(3'(a), 8'h00);
		$display("test abort done");
		wr(3'h2, 8'h80);
		wr(3'h0, 8'h3d);
		repeat (20) @(posedge i_clk);
		wr(3'h0, 8'h3f);
		repeat (60) @(posedge i_clk);
		#1 chk(16'(irq), 16'h0);
		rd(3'h5, 8'h01);
		wr(3'h6, 8'h01);
		rd(3'h6, 8'h01);
		chk(16'(irq), 16'h1);
		wr(3'h5, 8'h01);
		rd(3'h5, 8'h00);
		chk(16'(irq), 16'h0);
		$display("test interrupt done");
		wr(3'h2, 8'h03);
		wr(3'h0, 8'h3f);
		repeat (3) @(posedge i_clk);
		#1 chk(16'(smp), 16'h1);
		repeat (3) @(posedge i_clk);
		#1 chk(16'(smp), 16'h0);
		$display("test rc delay done");
		stop_test();
	end
endmodule

`default_nettype wire
